/* File: hw/period_timer_pkg.sv */
// Constants, mode codes and the state record of the 8-bit period timer.
// Assumes one 10 MHz system clock; every slower rate is an enable pulse.
package period_timer_pkg;

	// Widths of the control fields and of the count.
	localparam int CNT_W      = 8;
	localparam int PRESC_W    = 7;
	localparam int PS_SEL_W   = 3;
	localparam int POST_SEL_W = 4;
	localparam int MODE_W     = 5;
	localparam int SRC_SEL_W  = 4;
	localparam int NUM_SRC    = 16;
	localparam int FLAG_SYNC  = 2;

	// Reset and restart values.
	localparam logic [CNT_W-1:0]      COUNT_ZERO = 8'h00;
	localparam logic [PRESC_W-1:0]    PRESC_ZERO = 7'h00;
	localparam logic [POST_SEL_W-1:0] POST_ZERO  = 4'h0;

	// Mode class in the upper two mode bits.
	localparam logic [1:0] CLS_FREE = 2'h0;
	localparam logic [1:0] CLS_ONE  = 2'h1;
	localparam logic [1:0] CLS_MONO = 2'h2;

	// Sub-mode codes in the lower three mode bits.
	localparam logic [2:0] SUB_SW    = 3'h0;
	localparam logic [2:0] SUB_GHI   = 3'h1;
	localparam logic [2:0] SUB_GLO   = 3'h2;
	localparam logic [2:0] SUB_ANY   = 3'h3;
	localparam logic [2:0] SUB_RISE  = 3'h4;
	localparam logic [2:0] SUB_FALL  = 3'h5;
	localparam logic [2:0] SUB_LOW   = 3'h6;
	localparam logic [2:0] SUB_HIGH  = 3'h7;

	// Whole mode codes that the gate logic and the checks test directly.
	localparam logic [MODE_W-1:0] MODE_SW_GATE = 5'h00;
	localparam logic [MODE_W-1:0] MODE_GATE_HI = 5'h01;
	localparam logic [MODE_W-1:0] MODE_GATE_LO = 5'h02;

	// Start state of the edge and software started modes.
	typedef enum logic [0:0] {
		ST_WAIT = 1'b0,
		ST_RUN  = 1'b1
	} run_state_t;

	// Every flip-flop of the timer.
	typedef struct packed {
		logic                  on;
		logic [1:0]            on_pipe;
		logic [1:0]            ers_pipe;
		logic                  ers_prev;
		logic                  tclk_prev;
		logic [PRESC_W-1:0]    presc;
		logic [CNT_W-1:0]      count;
		logic [POST_SEL_W-1:0] post;
		logic                  post_pulse;
		logic                  match_pulse;
		logic [FLAG_SYNC-1:0]  flag_pipe;
		logic                  flag;
		run_state_t            state;
	} state_t;

	localparam state_t STATE_RESET = '{
		on: 1'b0, on_pipe: 2'h0, ers_pipe: 2'h0, ers_prev: 1'b0, tclk_prev: 1'b0,
		presc: PRESC_ZERO, count: COUNT_ZERO, post: POST_ZERO, post_pulse: 1'b0,
		match_pulse: 1'b0, flag_pipe: 2'h0, flag: 1'b0, state: ST_WAIT};

endpackage : period_timer_pkg

/* File: hw/period_timer.sv */
// Period timer with prescaler, postscaler and external reset/gate input.
// Assumes all inputs are synchronous to clock; count_clock is a level sampled here.
//
// Function
// - Edge-started modes need a fresh edge after run enable was cleared and set again.
// - One-shot modes: clock after count equals period clears run enable, count stops at zero.
// - Monostable modes: clock after match stops count at zero, run enable stays set.
// - Interrupt flag rises when postscaler reaches the selected ratio, 1:1 to 1:16.
// - Interrupt request reaches the processor only while its enable bit is set.
// - Interrupt flag setting may lag the postscaled match by two instruction cycles.
// - Slow timer clock: run enable and external signal delayed two timer clocks.
// - Instruction clock: external signal delayed one cycle, run enable next cycle.
// - Software gate mode counts while run enable is set, holds while clear.
// - Count equal to period returns to zero on next prescaler expiry, keeps counting in free-running modes.
// - Hardware gate modes also gate by external signal; high level runs in mode 00001.
// - Gating lengthens PWM period, and duty when stopped with PWM output high.
// - Five-bit mode field selects free-running, one-shot or monostable variants.
// - External reset/gate signal comes from a source chosen by a select register.
`timescale 1ns/1ps

module period_timer
	import period_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	// Timer clock source.
	input  wire logic                  use_instr_clock,
	input  wire logic                  count_clock,
	// Software control bits.
	input  wire logic                  run_enable_wr,
	input  wire logic                  run_enable_wdata,
	input  wire logic [MODE_W-1:0]     limit_mode_reg,
	input  wire logic [PS_SEL_W-1:0]   prescale_select,
	input  wire logic [POST_SEL_W-1:0] postscale_select,
	input  wire logic [CNT_W-1:0]      period_match_reg,
	input  wire logic [SRC_SEL_W-1:0]  ext_reset_select_reg,
	input  wire logic                  period_irq_enable,
	input  wire logic                  period_irq_flag_clr,
	// External reset/gate sources.
	input  wire logic [NUM_SRC-1:0]    ext_reset_sources,
	// Status and results.
	output logic                       run_enable,
	output logic [CNT_W-1:0]           count_value,
	output logic                       period_match_pulse,
	output logic                       postscaled_match_pulse,
	output logic                       period_irq_flag,
	output logic                       timer_irq_request
);

	state_t st_q;
	state_t st_d;

	// Decoded strobes shared by the update logic and the checks.
	logic ext_reset_signal;
	logic tick;
	logic on_s;
	logic ers_s;
	logic rise;
	logic fall;
	logic presc_done;
	logic running;
	logic hw_reset;
	logic at_match;
	logic wrap;
	logic one_shot;
	logic mono;
	logic level_start;

	// Start event of the edge-started modes; software start always qualifies.
	function automatic logic start_event(input logic [2:0] sub, input logic r, input logic f);
		unique case (sub)
			SUB_GHI, SUB_RISE, SUB_LOW:  start_event = r;
			SUB_GLO, SUB_FALL, SUB_HIGH: start_event = f;
			SUB_ANY:                     start_event = r | f;
			SUB_SW:                      start_event = 1'b1;
		endcase
	endfunction : start_event

	// Hardware reset of the count, by edge or by level, per mode class.
	function automatic logic reset_event(input logic [1:0] cls, input logic [2:0] sub,
			input logic e, input logic r, input logic f);
		reset_event = 1'b0;
		if ((cls == CLS_FREE && sub == SUB_ANY)) begin
			reset_event = r | f;
		end else if (cls == CLS_FREE || cls == CLS_ONE) begin
			unique case (sub)
				SUB_RISE: reset_event = r;
				SUB_FALL: reset_event = f;
				SUB_LOW:  reset_event = ~e;
				SUB_HIGH: reset_event = e;
				default:  reset_event = 1'b0;
			endcase
		end else if (cls == CLS_MONO && sub == SUB_LOW) begin
			reset_event = ~e;
		end else if (cls == CLS_MONO && sub == SUB_HIGH) begin
			reset_event = e;
		end
	endfunction : reset_event

	// Source selection and timer clock tick; a slow timer clock is edge detected here.
	assign ext_reset_signal = ext_reset_sources[ext_reset_select_reg];
	assign tick = use_instr_clock | (count_clock & ~st_q.tclk_prev);
	// The instruction clock needs one stage, a slower clock two of its own ticks.
	assign on_s  = use_instr_clock ? st_q.on_pipe[0] : st_q.on_pipe[1];
	assign ers_s = use_instr_clock ? st_q.ers_pipe[0] : st_q.ers_pipe[1];
	assign rise  = ers_s & ~st_q.ers_prev;
	assign fall  = ~ers_s & st_q.ers_prev;

	// Mode decode.
	assign one_shot    = limit_mode_reg[4:3] == CLS_ONE;
	assign mono        = limit_mode_reg[4:3] == CLS_MONO &&
		limit_mode_reg[2:0] inside {SUB_GHI, SUB_GLO, SUB_ANY};
	assign level_start = limit_mode_reg[4:3] == CLS_MONO && limit_mode_reg[2] && limit_mode_reg[1];
	assign hw_reset    = tick &&
		reset_event(limit_mode_reg[4:3], limit_mode_reg[2:0], ers_s, rise, fall);

	// Run condition per mode; reserved codes never run.
	always_comb begin
		running = 1'b0;
		if (limit_mode_reg == MODE_GATE_HI) begin
			running = on_s & ers_s;
		end else if (limit_mode_reg == MODE_GATE_LO) begin
			running = on_s & ~ers_s;
		end else if (limit_mode_reg[4:3] == CLS_FREE) begin
			running = on_s;
		end else if (level_start) begin
			running = on_s & (limit_mode_reg[0] ? ~ers_s : ers_s);
		end else if (one_shot || mono) begin
			running = on_s & (st_q.state == ST_RUN);
		end
	end

	// Prescaler expiry: the ratio is two to the power of the select field.
	assign presc_done = tick && running &&
		((st_q.presc & PRESC_W'((1 << prescale_select) - 1)) ==
		PRESC_W'((1 << prescale_select) - 1));
	assign at_match = presc_done && !hw_reset && st_q.count == period_match_reg;
	assign wrap     = at_match && !one_shot && !mono && !level_start;

	// Next state of every register.
	always_comb begin
		st_d = st_q;
		st_d.post_pulse  = 1'b0;
		st_d.match_pulse = 1'b0;
		st_d.flag_pipe   = {st_q.flag_pipe[0], 1'b0};
		if (!use_instr_clock) begin
			st_d.tclk_prev = count_clock;
		end
		// Synchronising pipes advance only on timer clock ticks.
		if (tick) begin
			st_d.on_pipe  = {st_q.on_pipe[0], st_q.on};
			st_d.ers_pipe = {st_q.ers_pipe[0], ext_reset_signal};
			st_d.ers_prev = ers_s;
		end
		// Start state: a cleared run enable forgets any earlier start.
		if (tick && !on_s) begin
			st_d.state = ST_WAIT;
		end else if (tick && st_q.state == ST_WAIT &&
				start_event(limit_mode_reg[2:0], rise, fall)) begin
			st_d.state = ST_RUN;
		end
		// Counting; a held count keeps the PWM period and duty stretched.
		if (hw_reset) begin
			st_d.count = COUNT_ZERO;
			st_d.presc = PRESC_ZERO;
		end else if (tick && running) begin
			st_d.presc = st_q.presc + 1'b1;
		end
		if (presc_done && !hw_reset) begin
			st_d.presc = PRESC_ZERO;
			st_d.count = st_q.count + 1'b1;
		end
		if (at_match) begin
			st_d.count       = COUNT_ZERO;
			st_d.match_pulse = 1'b1;
			if (st_q.post == postscale_select) begin
				st_d.post       = POST_ZERO;
				st_d.post_pulse = 1'b1;
				// The flag pipe starts with the pulse, so the flag follows two cycles later.
				st_d.flag_pipe[0] = 1'b1;
			end else begin
				st_d.post = st_q.post + 1'b1;
			end
		end
		// One-shot stops and drops run enable, including its pipe, so no restart.
		if (at_match && (one_shot || level_start)) begin
			st_d.on      = 1'b0;
			st_d.on_pipe = 2'h0;
			st_d.state   = ST_WAIT;
		end else if (at_match && mono) begin
			st_d.state = ST_WAIT;
		end
		// A software write is the newer intent, so it wins over the hardware stop.
		if (run_enable_wr) begin
			st_d.on = run_enable_wdata;
		end
		// Set wins over clear for the interrupt flag.
		if (st_q.flag_pipe[FLAG_SYNC-1]) begin
			st_d.flag = 1'b1;
		end else if (period_irq_flag_clr) begin
			st_d.flag = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			st_q <= STATE_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs.
	assign run_enable             = st_q.on;
	assign count_value            = st_q.count;
	assign period_match_pulse     = st_q.match_pulse;
	assign postscaled_match_pulse = st_q.post_pulse;
	assign period_irq_flag        = st_q.flag;
	assign timer_irq_request      = st_q.flag & period_irq_enable;

	// Checks. They watch the registered outputs and a few decoded strobes, so a
	// wrong decode shows up as a failing property rather than as a silent miscount.
	sequence oneshot_match_s;
		at_match && one_shot && !run_enable_wr;
	endsequence
	sequence mono_match_s;
		at_match && mono && run_enable && !run_enable_wr;
	endsequence

	oneshot_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
		oneshot_match_s |=> !run_enable && count_value == COUNT_ZERO && !running)
		else $error("one-shot match did not stop the timer");
	mono_stop_a: assert property (@(posedge clock) disable iff (sys_rst)
		mono_match_s |=> run_enable && count_value == COUNT_ZERO && st_q.state == ST_WAIT)
		else $error("monostable match did not hold at zero");
	restart_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
		tick && !on_s |=> st_q.state == ST_WAIT)
		else $error("start state kept while run enable low");
	flag_delay_a: assert property (@(posedge clock) disable iff (sys_rst)
		postscaled_match_pulse |-> ##2 period_irq_flag)
		else $error("interrupt flag not set two cycles after postscaled match");
	irq_gate_a: assert property (@(posedge clock) disable iff (sys_rst)
		timer_irq_request |-> period_irq_enable && period_irq_flag)
		else $error("interrupt request without enable");
	wrap_zero_a: assert property (@(posedge clock) disable iff (sys_rst)
		wrap && !run_enable_wr && period_match_reg != COUNT_ZERO |=>
		count_value == COUNT_ZERO ##1 period_match_pulse == 1'b0)
		else $error("count did not wrap to zero after period match");
	sw_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		limit_mode_reg == MODE_SW_GATE && !on_s |=> $stable(count_value))
		else $error("count moved while run enable low");
	gate_low_a: assert property (@(posedge clock) disable iff (sys_rst)
		limit_mode_reg == MODE_GATE_LO && ers_s && !hw_reset |=> $stable(count_value))
		else $error("active-low gate counted while signal high");
	gate_high_a: assert property (@(posedge clock) disable iff (sys_rst)
		limit_mode_reg == MODE_GATE_HI && !ers_s |=> $stable(count_value))
		else $error("active-high gate counted while signal low");
	presc_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		$changed(count_value) && count_value != COUNT_ZERO |-> $past(presc_done))
		else $error("count advanced without prescaler expiry");
	on_sync_a: assert property (@(posedge clock) disable iff (sys_rst)
		!use_instr_clock && !tick && !run_enable_wr |=> $stable(on_s))
		else $error("run enable resynchronised between timer clocks");

	// Edge-started modes wait in the start state until a delayed edge shows up.
	start_edge_a: assert property (@(posedge clock) disable iff (sys_rst)
		(mono || (one_shot && limit_mode_reg[2:0] != SUB_SW)) && st_q.state == ST_WAIT &&
		!rise && !fall |=> st_q.state == ST_WAIT)
		else $error("edge-started mode left the start state without an edge");

	// The flag is sticky, the request is masked, and a postscaled pulse rides on a match.
	flag_hold_a: assert property (@(posedge clock) disable iff (sys_rst)
		period_irq_flag && !period_irq_flag_clr |=> period_irq_flag)
		else $error("interrupt flag dropped without a clear");
	irq_off_a: assert property (@(posedge clock) disable iff (sys_rst)
		!period_irq_enable |-> !timer_irq_request)
		else $error("interrupt request raised while disabled");
	post_match_a: assert property (@(posedge clock) disable iff (sys_rst)
		postscaled_match_pulse |-> period_match_pulse)
		else $error("postscaled pulse without a period match");

	// A software gated count steps by exactly one per prescaler expiry below the period.
	count_step_a: assert property (@(posedge clock) disable iff (sys_rst)
		limit_mode_reg == MODE_SW_GATE && presc_done && count_value != period_match_reg
		|=> count_value == $past(count_value) + 8'h01)
		else $error("software gated count did not step by one");

	// A stopped one-shot never advances; only a hardware reset may still zero it.
	oneshot_idle_a: assert property (@(posedge clock) disable iff (sys_rst)
		one_shot && !on_s |=> count_value == $past(count_value) || count_value == COUNT_ZERO)
		else $error("stopped one-shot count advanced");

	// On the instruction clock a run enable write reaches the delayed copy one cycle on.
	sequence on_set_s;
		run_enable_wr && run_enable_wdata && use_instr_clock;
	endsequence
	sequence on_settle_s;
		use_instr_clock && !run_enable_wr && !at_match;
	endsequence
	instr_sync_a: assert property (@(posedge clock) disable iff (sys_rst)
		on_set_s ##1 on_settle_s |=> st_q.on_pipe[0])
		else $error("run enable not applied in the following cycle");

endmodule : period_timer

/* File: testbench/gate_source_model.sv */
// Behavioural source of the external reset/gate lines seen by the period timer.
// Assumes the timer clock equals the system clock whenever edges matter.
`timescale 1ns/1ps

module gate_source_model
	import period_timer_pkg::*;
(
	// Clock and reset.
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	// Level asked for by the bench and the line that carries it.
	input  wire logic                 want_level,
	input  wire logic [SRC_SEL_W-1:0] sel,
	// Candidate external lines.
	output logic      [NUM_SRC-1:0]   ext_reset_sources
);
	logic               level_q;
	logic [3:0]         hold_q;
	logic [NUM_SRC-1:0] noise_q;

	// A request waits until the old level has stood seven clocks, which also covers level hold.
	always @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			level_q <= 1'b0;
			hold_q  <= 4'h0;
			noise_q <= 16'hA5C3;
		end else begin
			noise_q <= {noise_q[14:0], ~noise_q[15]};
			if (want_level != level_q && hold_q >= 4'h6) begin
				level_q <= want_level;
				hold_q  <= 4'h0;
			end else if (hold_q != 4'hF) begin
				hold_q <= hold_q + 4'h1;
			end
		end
	end

	// Unselected lines carry a shifting pattern so that a wrong select cannot pass.
	always_comb begin
		ext_reset_sources      = noise_q;
		ext_reset_sources[sel] = level_q;
	end

endmodule : gate_source_model

/* File: testbench/period_timer_tb.sv */
// Self-checking bench for the period timer with a model of its gate source.
// Assumes the timer is on the system clock unless a scenario selects count_clock.
`timescale 1ns/1ps

module period_timer_tb
	import period_timer_pkg::*;
;
	logic                  clock = 0, sys_rst = 1, use_instr_clock = 1, count_clock = 0;
	logic                  run_enable_wr = 0, run_enable_wdata = 0, want_level = 0;
	logic [MODE_W-1:0]     limit_mode_reg = MODE_SW_GATE;
	logic [PS_SEL_W-1:0]   prescale_select = 0;
	logic [POST_SEL_W-1:0] postscale_select = 0;
	logic [CNT_W-1:0]      period_match_reg = 8'hFF, prev, expv;
	logic [SRC_SEL_W-1:0]  ext_reset_select_reg = 0;
	logic                  period_irq_enable = 0, period_irq_flag_clr = 0;
	logic [NUM_SRC-1:0]    ext_reset_sources;
	logic                  run_enable, period_match_pulse, postscaled_match_pulse;
	logic                  period_irq_flag, timer_irq_request;
	logic [CNT_W-1:0]      count_value;
	logic [2:0]            slow_div = 0;
	int                    n_mismatch = 0, tests_run = 0, c, n;
	logic [POST_SEL_W-1:0] n_post_list [3] = '{4'h0, 4'hF, 4'h5};

	period_timer period_timer_inst (.clock(clock), .sys_rst(sys_rst),
		.use_instr_clock(use_instr_clock), .count_clock(count_clock),
		.run_enable_wr(run_enable_wr), .run_enable_wdata(run_enable_wdata),
		.limit_mode_reg(limit_mode_reg), .prescale_select(prescale_select),
		.postscale_select(postscale_select), .period_match_reg(period_match_reg),
		.ext_reset_select_reg(ext_reset_select_reg), .period_irq_enable(period_irq_enable),
		.period_irq_flag_clr(period_irq_flag_clr), .ext_reset_sources(ext_reset_sources),
		.run_enable(run_enable), .count_value(count_value),
		.period_match_pulse(period_match_pulse), .postscaled_match_pulse(postscaled_match_pulse),
		.period_irq_flag(period_irq_flag), .timer_irq_request(timer_irq_request));
	gate_source_model gate_source_model_inst (.clock(clock), .sys_rst(sys_rst),
		.want_level(want_level), .sel(ext_reset_select_reg), .ext_reset_sources(ext_reset_sources));

	// Clock of 100 ns, and a slow timer clock whose rising edge comes every eight cycles.
	always #50 clock = ~clock;
	always @(posedge clock) begin
		#1 slow_div = slow_div + 3'h1;
		count_clock = slow_div[2];
	end

	// Inputs always move 1 ns after the edge, so the design samples settled values.
	task automatic tick();
		@(posedge clock);
		#1;
	endtask : tick
	task automatic check(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask : check
	task automatic set_run(input logic v);
		run_enable_wr = 1;
		run_enable_wdata = v;
		tick();
		run_enable_wr = 0;
	endtask : set_run
	// Cycles until the count moves; bounded so a stuck counter cannot hang the run.
	task automatic gap();
		prev = count_value;
		c = 0;
		while (count_value === prev && c < 400) begin
			tick();
			c++;
		end
	endtask : gap
	task automatic wait_pulse(input bit post);
		c = 0;
		while ((post ? postscaled_match_pulse : period_match_pulse) !== 1'b1 && c < 3000) begin
			tick();
			c++;
		end
	endtask : wait_pulse
	// Counting shows as a moved count some cycles after the gate settles.
	task automatic gate_check(input logic runs);
		repeat (10) tick();
		prev = count_value;
		repeat (5) tick();
		check((count_value !== prev) === runs, "gate control of counting");
	endtask : gate_check
	function automatic int ratio(input int code);
		return 1 << code;
	endfunction : ratio
	task automatic complete_run();
		$display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run

	// Watchdog sized well above the longest expected sequence.
	initial begin
		#(60000 * 100);
		n_mismatch++;
		complete_run();
	end

	initial begin
		void'($urandom(19848));
		ext_reset_select_reg = 4'($urandom % 16);
		repeat (6) tick();
		sys_rst = 0;
		tick();
		check(count_value === COUNT_ZERO && run_enable === 1'b0, "reset values");
		// Software gate: increment, wrap after the period value, pause while disabled.
		period_match_reg = 8'(2 + $urandom % 8);
		set_run(1);
		check(run_enable === 1'b1, "run enable write");
		gap();
		check(c == 2, "start latency");
		repeat (3 * (period_match_reg + 1)) begin
			prev = count_value;
			tick();
			expv = (prev == period_match_reg) ? COUNT_ZERO : prev + 8'h01;
			check(count_value === expv, "count sequence");
			check(period_match_pulse === (prev == period_match_reg), "match pulse");
		end
		set_run(0);
		gate_check(0);
		// Every prescale code, then the slow timer clock.
		period_match_reg = 8'hFF;
		set_run(1);
		for (int k = 0; k < 8; k++) begin
			prescale_select = 3'(k);
			gap();
			gap();
			check(c == ratio(k), "prescale interval");
		end
		prescale_select = 0;
		set_run(0);
		use_instr_clock = 0;
		repeat (20) tick();
		set_run(1);
		gap();
		check(c >= 16, "slow clock start delay");
		gap();
		check(c == 8, "slow clock interval");
		use_instr_clock = 1;
		// Postscaler ratios, flag delay, enable gating and flag clear.
		foreach (n_post_list[i]) begin
			postscale_select = n_post_list[i];
			period_irq_enable = 1'($urandom);
			// A period of at least two keeps the next match clear of the flag checks.
			period_match_reg = 8'(2 + $urandom % 4);
			set_run(0);
			repeat (8) tick();
			period_irq_flag_clr = 1;
			tick();
			period_irq_flag_clr = 0;
			check(period_irq_flag === 1'b0 && timer_irq_request === 1'b0, "flag clear");
			set_run(1);
			wait_pulse(1);
			tick();
			check(period_irq_flag === 1'b0, "flag too early");
			tick();
			check(period_irq_flag === 1'b1, "flag after postscaled match");
			check(timer_irq_request === period_irq_enable, "request gating");
			n = 0;
			do begin
				tick();
				n += period_match_pulse;
			end while (postscaled_match_pulse !== 1'b1 && n < 40);
			check(n == postscale_select + 1, "postscale ratio");
		end
		// Hardware gate, active high then active low.
		period_match_reg = 8'hFF;
		limit_mode_reg = MODE_GATE_HI;
		gate_check(0);
		want_level = 1;
		gate_check(1);
		limit_mode_reg = MODE_GATE_LO;
		gate_check(0);
		want_level = 0;
		gate_check(1);
		set_run(0);
		gate_check(0);
		// One-shot stops and clears run enable.
		limit_mode_reg = {CLS_ONE, SUB_SW};
		period_match_reg = 8'h03;
		set_run(1);
		wait_pulse(0);
		repeat (2) tick();
		check(run_enable === 1'b0 && count_value === COUNT_ZERO, "one-shot stop");
		gate_check(0);
		// Monostable, rising edge start: needs an edge, stops with run enable kept.
		limit_mode_reg = {CLS_MONO, SUB_GHI};
		period_match_reg = 8'h20;
		set_run(1);
		gate_check(0);
		want_level = 1;
		wait_pulse(0);
		repeat (3) tick();
		check(run_enable === 1'b1 && count_value === COUNT_ZERO, "monostable stop");
		set_run(0);
		tick();
		set_run(1);
		want_level = 0;
		gate_check(0);
		want_level = 1;
		gate_check(1);
		complete_run();
	end

endmodule : period_timer_tb
